// ===== mhbe_pkg.sv
// Constants, command codes and types shared by the host bus emulation engine.
`default_nettype none
package mhbe_pkg;
    // Mode-select values.
    localparam logic [7:0] MHBE_MODE_BUS   = 8'h08;
    localparam logic [7:0] MHBE_MODE_RESET = 8'h00;
    // Host command codes.
    localparam logic [3:0] MHBE_CMD_READ      = 4'h0;
    localparam logic [3:0] MHBE_CMD_READ_EXT  = 4'h1;
    localparam logic [3:0] MHBE_CMD_WRITE     = 4'h2;
    localparam logic [3:0] MHBE_CMD_WRITE_EXT = 4'h3;
    localparam logic [3:0] MHBE_CMD_AUX_SET   = 4'h4;
    localparam logic [3:0] MHBE_CMD_AUX_READ  = 4'h5;
    localparam logic [3:0] MHBE_CMD_WAIT_HIGH = 4'h6;
    localparam logic [3:0] MHBE_CMD_WAIT_LOW  = 4'h7;
    // Reset values of the pins.
    localparam logic [7:0] MHBE_UPPER_RST = 8'h00;
    localparam logic [1:0] MHBE_AUX_RST   = 2'h0;
    // Bus timing: clock period, one bus clock period, cycles per bus clock.
    localparam int MHBE_CLK_NS      = 10;
    localparam int MHBE_BUS_CLK_NS  = 100;
    localparam int MHBE_BUS_DIV     = (MHBE_BUS_CLK_NS + MHBE_CLK_NS - 1) / MHBE_CLK_NS;
    localparam logic [3:0] MHBE_DIV_LAST = 4'(MHBE_BUS_DIV - 1);
    // Sequencer states, Gray coded along the access path.
    typedef enum logic [3:0] {
        MHBE_IDLE  = 4'b0000,
        MHBE_ADDR  = 4'b0001,
        MHBE_LATCH = 4'b0011,
        MHBE_SEL   = 4'b0010,
        MHBE_DATA  = 4'b0110,
        MHBE_STRB  = 4'b0111,
        MHBE_HOLD  = 4'b0101,
        MHBE_WAITP = 4'b1100,
        MHBE_DONE  = 4'b0100
    } mhbe_state_t;
endpackage : mhbe_pkg
`default_nettype wire

// ===== mhbe_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module mhbe_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : mhbe_sync
`default_nettype wire

// ===== mhbe_core.sv
// Host bus emulation engine: runs host commands as multiplexed bus cycles.
//
// What this block does
// - Bus mode merges both channels into one bus.
// - Address low byte and data share eight lines.
// - Eight separate outputs carry the upper address.
// - Four accesses; plain read keeps upper address.
// - Extended read loads upper address first.
// - Plain write keeps, extended write loads upper.
// - Mode value 8 enters, value 0 resets.
// - Two auxiliary lines set, cleared or read.
// - Stall until auxiliary line 1 high, or low.
// - After wait, read peripheral and return byte.
// - Address, setup clock, latch pulse, select, data.
// - Latch pulse stretches to two if wait low.
// - Wait input low extends the access.
// - Write data stable around write strobe.
`timescale 1ns/1ps
`default_nettype none
module mhbe_core
    import mhbe_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic       mode_valid_i,
    input  wire logic [7:0] mode_value_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [3:0] cmd_code_i,
    input  wire logic [7:0] cmd_addr_lo_i,
    input  wire logic [7:0] cmd_addr_hi_i,
    input  wire logic [7:0] cmd_data_i,
    output logic            cmd_ready_o,
    output logic            rsp_valid_o,
    output logic [7:0]      rsp_data_o,
    output logic            mode_active_o,
    input  wire logic [7:0] muxed_bus_i,
    output logic [7:0]      muxed_bus_o,
    output logic            muxed_bus_oe_o,
    output logic [7:0]      upper_address_o,
    output logic            latch_o,
    output logic            select_n_o,
    output logic            read_n_o,
    output logic            write_n_o,
    input  wire logic       bus_wait_in_i,
    input  wire logic [1:0] aux_i,
    output logic [1:0]      aux_o,
    output logic [1:0]      aux_oe_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [7:0]  bus_s;
    logic [2:0]  pins_s;
    logic        wait_low;
    logic [1:0]  aux_s;

    mhbe_sync #(.W(8)) u_sync_bus (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (muxed_bus_i),
        .sync_o    (bus_s)
    );
    mhbe_sync #(.W(3)) u_sync_ctl (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   ({bus_wait_in_i, aux_i}),
        .sync_o    (pins_s)
    );
    // Wait input and auxiliary lines after synchronisation.
    assign wait_low = ~pins_s[2];
    assign aux_s    = pins_s[1:0];

    // ------------------------------------------------------------
    // Bus clock divider
    // ------------------------------------------------------------
    logic [3:0]  div_q;
    logic        tick;
    mhbe_state_t state_q;

    // Makes a one-cycle enable for each bus clock period; it restarts while no access
    // runs, so the address setup phase is always one full bus clock long.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 4'h0;
        end else if (div_q == MHBE_DIV_LAST || state_q == MHBE_IDLE ||
                     state_q == MHBE_WAITP) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    assign tick = (div_q == MHBE_DIV_LAST);

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    logic mode_q;

    // Only value 8 enables bus mode; 0 or any other value leaves it.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= 1'b0;
        end else if (mode_valid_i) begin
            mode_q <= (mode_value_i == MHBE_MODE_BUS);
        end
    end
    // Channels act as one bus only while the mode is on.
    assign mode_active_o = mode_q;

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    logic        is_read_q;
    logic        wait_lvl_q;
    logic        stretch_q;
    logic [7:0]  addr_lo_q;
    logic [7:0]  data_q;
    logic        reset_cmd;

    assign reset_cmd = mode_valid_i && (mode_value_i == MHBE_MODE_RESET);

    // Steps through address, latch, select, data and strobe phases.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q    <= MHBE_IDLE;
            is_read_q  <= 1'b0;
            wait_lvl_q <= 1'b0;
            stretch_q  <= 1'b0;
            addr_lo_q  <= 8'h00;
            data_q     <= 8'h00;
        end else if (reset_cmd || !mode_q) begin
            state_q   <= MHBE_IDLE;
            stretch_q <= 1'b0;
        end else begin
            case (state_q)
                MHBE_IDLE: begin
                    if (cmd_valid_i) begin
                        addr_lo_q <= cmd_addr_lo_i;
                        data_q    <= cmd_data_i;
                        case (cmd_code_i)
                            MHBE_CMD_READ, MHBE_CMD_READ_EXT: begin
                                is_read_q <= 1'b1;
                                state_q   <= MHBE_ADDR;
                            end
                            MHBE_CMD_WRITE, MHBE_CMD_WRITE_EXT: begin
                                is_read_q <= 1'b0;
                                state_q   <= MHBE_ADDR;
                            end
                            MHBE_CMD_WAIT_HIGH, MHBE_CMD_WAIT_LOW: begin
                                is_read_q  <= 1'b1;
                                wait_lvl_q <= (cmd_code_i == MHBE_CMD_WAIT_HIGH);
                                state_q    <= MHBE_WAITP;
                            end
                            default: begin
                                state_q <= MHBE_IDLE;
                            end
                        endcase
                    end
                end
                MHBE_WAITP: begin
                    // Once the line matches, go on to read the peripheral.
                    if (aux_s[1] == wait_lvl_q) begin
                        state_q <= MHBE_ADDR;
                    end
                end
                MHBE_ADDR: begin
                    // One bus clock of address setup.
                    if (tick) begin
                        state_q <= MHBE_LATCH;
                    end
                end
                MHBE_LATCH: begin
                    // Latch pulse is one bus clock, two if wait is low.
                    if (tick) begin
                        if (wait_low && !stretch_q) begin
                            stretch_q <= 1'b1;
                        end else begin
                            stretch_q <= 1'b0;
                            state_q   <= MHBE_SEL;
                        end
                    end
                end
                MHBE_SEL: begin
                    if (tick) begin
                        state_q <= MHBE_DATA;
                    end
                end
                MHBE_DATA: begin
                    // Write data or bus turnaround before the strobe.
                    if (tick) begin
                        state_q <= MHBE_STRB;
                    end
                end
                MHBE_STRB: begin
                    // Strobe held while the peripheral pulls wait low.
                    if (tick && !wait_low) begin
                        state_q <= MHBE_HOLD;
                        if (is_read_q) begin
                            data_q <= bus_s;
                        end
                    end
                end
                MHBE_HOLD: begin
                    if (tick) begin
                        state_q <= MHBE_DONE;
                    end
                end
                MHBE_DONE: begin
                    state_q <= MHBE_IDLE;
                end
                default: begin
                    state_q <= MHBE_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Upper address byte
    // ------------------------------------------------------------
    // Only extended accesses load new upper address bits.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            upper_address_o <= MHBE_UPPER_RST;
        end else if (mode_q && state_q == MHBE_IDLE && cmd_valid_i &&
                     (cmd_code_i == MHBE_CMD_READ_EXT ||
                      cmd_code_i == MHBE_CMD_WRITE_EXT)) begin
            upper_address_o <= cmd_addr_hi_i;
        end
    end

    // ------------------------------------------------------------
    // Bus pin drivers
    // ------------------------------------------------------------
    mhbe_state_t nxt;
    assign nxt = state_q;

    // Registered strobes and multiplexed bus drive.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            muxed_bus_o    <= 8'h00;
            muxed_bus_oe_o <= 1'b0;
            latch_o        <= 1'b0;
            select_n_o     <= 1'b1;
            read_n_o       <= 1'b1;
            write_n_o      <= 1'b1;
        end else begin
            latch_o    <= (nxt == MHBE_LATCH);
            select_n_o <= !(nxt == MHBE_SEL || nxt == MHBE_DATA ||
                            nxt == MHBE_STRB || nxt == MHBE_HOLD);
            read_n_o   <= !(is_read_q && nxt == MHBE_STRB);
            write_n_o  <= !(!is_read_q && nxt == MHBE_STRB);
            if (nxt == MHBE_ADDR || nxt == MHBE_LATCH) begin
                muxed_bus_o    <= addr_lo_q;
                muxed_bus_oe_o <= 1'b1;
            end else if (!is_read_q && (nxt == MHBE_DATA || nxt == MHBE_STRB ||
                                        nxt == MHBE_HOLD)) begin
                muxed_bus_o    <= data_q;
                muxed_bus_oe_o <= 1'b1;
            end else begin
                muxed_bus_oe_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Auxiliary lines
    // ------------------------------------------------------------
    // Set or clear the auxiliary lines; a zero enable leaves a line as input.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_o    <= MHBE_AUX_RST;
            aux_oe_o <= MHBE_AUX_RST;
        end else if (mode_q && state_q == MHBE_IDLE && cmd_valid_i &&
                     cmd_code_i == MHBE_CMD_AUX_SET) begin
            aux_o    <= cmd_data_i[1:0];
            aux_oe_o <= cmd_addr_lo_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // Host answers
    // ------------------------------------------------------------
    // Read data or auxiliary state returned as a one-cycle pulse.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 8'h00;
            cmd_ready_o <= 1'b0;
        end else begin
            cmd_ready_o <= mode_q && (state_q == MHBE_IDLE) && !cmd_valid_i;
            if (mode_q && state_q == MHBE_DONE && is_read_q) begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= data_q;
            end else if (mode_q && state_q == MHBE_IDLE && cmd_valid_i &&
                         cmd_code_i == MHBE_CMD_AUX_READ) begin
                rsp_valid_o <= 1'b1;
                rsp_data_o  <= {6'h00, aux_s};
            end else begin
                rsp_valid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_MODE_ENTRY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mode_valid_i && mode_value_i == MHBE_MODE_BUS |=> mode_active_o)
        else $error("Mode value 8 did not enable bus mode.");
    AST_MODE_EXIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        mode_valid_i && mode_value_i == MHBE_MODE_RESET |=> !mode_active_o)
        else $error("Mode value 0 did not leave bus mode.");
    AST_UPPER_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_q != MHBE_IDLE |=> $stable(upper_address_o))
        else $error("Upper address changed during an access.");
    AST_NO_CONTENTION: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !read_n_o |-> !muxed_bus_oe_o)
        else $error("Bus driven while read strobe active.");
    AST_WR_DATA: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !write_n_o |-> muxed_bus_oe_o && $stable(muxed_bus_o))
        else $error("Write data not stable under write strobe.");
    AST_WR_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(write_n_o) |-> muxed_bus_oe_o)
        else $error("Write data dropped with the strobe.");
    AST_SEL_STROBE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!read_n_o || !write_n_o) |-> !select_n_o && !latch_o)
        else $error("Strobe without chip select.");
    AST_LATCH_ADDR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        latch_o |-> muxed_bus_oe_o && muxed_bus_o == addr_lo_q)
        else $error("Latch pulse without low address on bus.");
    AST_WAIT_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_q == MHBE_STRB && wait_low && mode_q && !reset_cmd
        |=> state_q == MHBE_STRB)
        else $error("Strobe ended while wait held low.");
    AST_WAIT_STALL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        state_q == MHBE_WAITP && aux_s[1] != wait_lvl_q && mode_q && !reset_cmd
        |=> state_q == MHBE_WAITP)
        else $error("Wait instruction released early.");
endmodule : mhbe_core
`default_nettype wire

// ===== mhbe_periph_model.sv
// Peripheral chip model on the multiplexed bus: byte store, wait stalls and timing probes.
`timescale 1ns/1ps
`default_nettype none
module mhbe_periph_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] bus_drv_i,
    input  wire logic       bus_oe_i,
    input  wire logic [7:0] upper_i,
    input  wire logic       latch_i,
    input  wire logic       select_n_i,
    input  wire logic       read_n_i,
    input  wire logic       write_n_i,
    input  var  int         stall_i,
    input  wire logic       latch_wait_i,
    output logic [7:0]      bus_o,
    output logic            rdy_o,
    output int              latch_len_o,
    output int              strb_len_o,
    output int              fault_o
);
    logic [7:0]  mem [logic [15:0]];
    logic [15:0] addr_q;
    logic [7:0]  rdata_q;
    logic [7:0]  prev_q;
    logic        latch_q;
    logic        wr_q;
    logic        idle;
    int          lat_q;
    int          str_q;
    assign idle = read_n_i & write_n_i;
    // The device drive wins; a selected read shows the store; otherwise the pull-ups.
    assign bus_o = bus_oe_i ? bus_drv_i : (!read_n_i && !select_n_i) ? rdata_q : 8'hff;
    // Wait is low through the latch on request, or for a set stall on each strobe.
    assign rdy_o = !((latch_wait_i && latch_i) || (!idle && str_q < stall_i));
    // Counters start clear.
    initial begin
        {lat_q, str_q, latch_len_o, strb_len_o, fault_o} = '0;
        latch_q = 1'b0;
        wr_q = 1'b1;
    end
    // Latch the address, serve the byte, store writes and measure pulse widths.
    always @(posedge sys_clk_i) begin
        latch_q <= latch_i;
        wr_q    <= write_n_i;
        prev_q  <= bus_o;
        lat_q   <= latch_i ? lat_q + 1 : 0;
        str_q   <= idle ? 0 : str_q + 1;
        if (latch_i) addr_q <= {upper_i, bus_o};
        if (latch_q && !latch_i) begin
            latch_len_o <= lat_q;
            rdata_q <= mem.exists(addr_q) ? mem[addr_q] : addr_q[15:8] ^ addr_q[7:0];
        end
        if (idle && str_q != 0) strb_len_o <= str_q;
        if (write_n_i && !wr_q) mem[addr_q] = bus_o;
        if ((!read_n_i && bus_oe_i) || (!write_n_i && (!bus_oe_i || (!wr_q && bus_o != prev_q))))
            fault_o <= fault_o + 1;
    end
endmodule : mhbe_periph_model
`default_nettype wire

// ===== mcu_host_bus_emulation_tb_top.sv
// Self-checking testbench for the host bus emulation engine.
`timescale 1ns/1ps
`default_nettype none
module mcu_host_bus_emulation_tb_top;
    import mhbe_pkg::*;
    logic       sys_clk, rst, mode_valid, cmd_valid, cmd_ready, rsp_valid, mode_active;
    logic       bus_oe, latch, select_n, read_n, write_n, rdy, latch_wait;
    logic [7:0] mode_value, addr_lo, addr_hi, wdata, rsp_data, bus_out, bus_in, upper, d;
    logic [3:0] code;
    logic [1:0] aux_tb, aux_in, aux_out, aux_oe;
    int         stall, latch_len, strb_len, fault, i, n_fail = 0, n_tests = 0;
    // Undriven auxiliary lines show what the bench puts on them.
    assign aux_in = (aux_oe & aux_out) | (~aux_oe & aux_tb);
    mhbe_core uut (.sys_clk_i(sys_clk), .rst_i(rst), .mode_valid_i(mode_valid),
        .mode_value_i(mode_value), .cmd_valid_i(cmd_valid), .cmd_code_i(code),
        .cmd_addr_lo_i(addr_lo), .cmd_addr_hi_i(addr_hi), .cmd_data_i(wdata),
        .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .mode_active_o(mode_active), .muxed_bus_i(bus_in), .muxed_bus_o(bus_out),
        .muxed_bus_oe_o(bus_oe), .upper_address_o(upper), .latch_o(latch),
        .select_n_o(select_n), .read_n_o(read_n), .write_n_o(write_n), .bus_wait_in_i(rdy),
        .aux_i(aux_in), .aux_o(aux_out), .aux_oe_o(aux_oe));
    mhbe_periph_model part (.sys_clk_i(sys_clk), .bus_drv_i(bus_out), .bus_oe_i(bus_oe),
        .upper_i(upper), .latch_i(latch), .select_n_i(select_n), .read_n_i(read_n),
        .write_n_i(write_n), .stall_i(stall), .latch_wait_i(latch_wait), .bus_o(bus_in),
        .rdy_o(rdy), .latch_len_o(latch_len), .strb_len_o(strb_len), .fault_o(fault));
    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // Bounded wait on a level; running out counts as a mismatch and ends the run.
    task automatic await(input string what, ref logic sig);
        for (i = 0; i < 700 && sig !== 1'b1; i++) tick(1);
        if (i == 700) begin
            check(what, 16'h0, 16'h1);
            results();
        end
    endtask : await
    task automatic set_mode(input logic [7:0] v);
        mode_value = v;
        mode_valid = 1'b1;
        tick(1);
        mode_valid = 1'b0;
        tick(3);
    endtask : set_mode
    // Present one command when ready; returns just after the taking edge.
    task automatic send(input logic [3:0] c, input logic [7:0] hi, lo, dt);
        await("cmd_ready", cmd_ready);
        {code, addr_hi, addr_lo, wdata} = {c, hi, lo, dt};
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
    endtask : send
    task automatic wr(input logic [3:0] c, input logic [7:0] hi, lo, dt);
        send(c, hi, lo, dt);
        tick(1);
        await("cmd_ready", cmd_ready);
    endtask : wr
    task automatic rd(input logic [3:0] c, input logic [7:0] hi, lo);
        send(c, hi, lo, 8'h00);
        await("rsp_valid", rsp_valid);
        d = rsp_data;
    endtask : rd
    // Counts response pulses over a quiet spell while a wait command stalls.
    task automatic quiet();
        int k = 0;
        repeat (100) begin
            tick(1);
            k += rsp_valid;
        end
        check("no early response", 16'(k), 16'h0);
    endtask : quiet
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_write();
        wr(MHBE_CMD_WRITE_EXT, 8'h12, 8'h34, 8'ha5);
        check("upper after ext write", upper, 8'h12);
        check("stored ext write", part.mem[16'h1234], 8'ha5);
        check("latch width", 16'(latch_len), 16'(MHBE_BUS_DIV));
        wr(MHBE_CMD_WRITE, 8'h77, 8'h35, 8'h5a);
        check("upper after plain write", upper, 8'h12);
        check("stored plain write", part.mem[16'h1235], 8'h5a);
    endtask : t_write
    task automatic t_read();
        rd(MHBE_CMD_READ_EXT, 8'h40, 8'h01);
        check("ext read data", d, 8'h41);
        check("upper after ext read", upper, 8'h40);
        rd(MHBE_CMD_READ, 8'h12, 8'h35);
        check("plain read data", d, 8'h75);
        check("upper after plain read", upper, 8'h40);
        rd(MHBE_CMD_READ_EXT, 8'h12, 8'h34);
        check("read back write", d, 8'ha5);
    endtask : t_read
    task automatic t_stretch();
        latch_wait = 1'b1;
        wr(MHBE_CMD_WRITE_EXT, 8'h20, 8'h10, 8'h3c);
        latch_wait = 1'b0;
        check("stretched latch", 16'(latch_len), 16'(2 * MHBE_BUS_DIV));
        stall = 25;
        wr(MHBE_CMD_WRITE, 8'h00, 8'h11, 8'hc3);
        check("write strobe held", strb_len >= 25 && strb_len <= 55, 1'b1);
        rd(MHBE_CMD_READ, 8'h00, 8'h10);
        check("stalled read data", d, 8'h3c);
        check("read strobe held", strb_len >= 25 && strb_len <= 55, 1'b1);
        stall = 0;
        check("bus contention or unstable data", 16'(fault), 16'h0);
    endtask : t_stretch
    task automatic t_aux();
        aux_tb = 2'b10;
        wr(MHBE_CMD_AUX_SET, 8'h00, 8'h01, 8'h01);
        check("aux drive", {aux_oe, aux_out[0]}, 3'b011);
        // The pins pass two synchronising flops before a read can see them.
        tick(2);
        rd(MHBE_CMD_AUX_READ, 8'h00, 8'h00);
        check("aux read", d, 8'h03);
        wr(MHBE_CMD_AUX_SET, 8'h00, 8'h01, 8'h00);
        tick(2);
        rd(MHBE_CMD_AUX_READ, 8'h00, 8'h00);
        check("aux cleared read", d, 8'h02);
    endtask : t_aux
    task automatic t_wait();
        aux_tb = 2'b00;
        send(MHBE_CMD_WAIT_HIGH, 8'hff, 8'h10, 8'h00);
        quiet();
        aux_tb = 2'b10;
        await("rsp_valid", rsp_valid);
        check("wait high read", rsp_data, 8'h3c);
        send(MHBE_CMD_WAIT_LOW, 8'hff, 8'h11, 8'h00);
        quiet();
        aux_tb = 2'b00;
        await("rsp_valid", rsp_valid);
        check("wait low read", rsp_data, 8'hc3);
        check("upper kept by wait", upper, 8'h20);
    endtask : t_wait
    task automatic t_mode_off();
        int k = 0;
        send(MHBE_CMD_READ_EXT, 8'h55, 8'h66, 8'h00);
        tick(20);
        set_mode(MHBE_MODE_RESET);
        check("abort strobes", {select_n, read_n, write_n, latch, bus_oe}, 5'b11100);
        check("mode off", {mode_active, cmd_ready}, 2'b00);
        {code, addr_lo, cmd_valid} = {MHBE_CMD_WRITE, 8'h01, 1'b1};
        repeat (100) begin
            tick(1);
            k += !select_n;
        end
        cmd_valid = 1'b0;
        check("no access out of mode", 16'(k), 16'h0);
        set_mode(MHBE_MODE_BUS);
        set_mode(8'h02);
        check("other mode value", mode_active, 1'b0);
    endtask : t_mode_off
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, mode_valid, mode_value, cmd_valid, code} = {1'b1, 1'b0, 8'h00, 1'b0, 4'h0};
        {addr_lo, addr_hi, wdata, aux_tb, stall, latch_wait} = '0;
        tick(6);
        check("reset strobes", {latch, select_n, read_n, write_n, bus_oe}, 5'b01110);
        check("reset state", {mode_active, cmd_ready, rsp_valid, upper}, {3'b000, MHBE_UPPER_RST});
        check("reset aux", {aux_out, aux_oe}, {MHBE_AUX_RST, 2'b00});
        rst = 1'b0;
        tick(2);
        set_mode(MHBE_MODE_BUS);
        check("mode on", mode_active, 1'b1);
        t_write();
        t_read();
        t_stretch();
        t_aux();
        t_wait();
        t_mode_off();
        results();
    end
endmodule : mcu_host_bus_emulation_tb_top
`default_nettype wire
